/* File: shared/port5_cfg_consts.svh */
// register indices, field positions and reset values of the port configuration bank
`ifndef PORT5_CFG_CONSTS_SVH
`define PORT5_CFG_CONSTS_SVH
`define IDX_PORT_ENABLE 8'h30
`define IDX_BASE_HIGH 8'h60
`define IDX_BASE_LOW 8'h61
`define IDX_IRQ_CHANNEL 8'h70
`define IDX_SHARE_CTRL 8'hF0
`define IDX_BAUD_CLOCK 8'hF2
`define IDX_SLAVE_ADDR 8'hF4
`define IDX_SLAVE_MASK 8'hF5
`define IDX_RX_STATUS 8'hF6
`define BIT_PORT_ON 0
`define BIT_MULTIDROP_ON 7
`define BIT_HW_MATCH_ON 6
`define BIT_POLARITY_FLIP 5
`define BIT_AUTO_DRIVE_ON 4
`define BIT_SHARE_STYLE 1
`define BIT_SHARED_FLAG 0
`define RST_PORT_ENABLE 8'h00
`define RST_BASE_HIGH 8'h00
`define RST_BASE_LOW 8'h00
`define RST_IRQ_CHANNEL 4'h3
`define RST_SHARE_CTRL 8'h00
`define RST_BAUD_CLOCK 2'h0
`define RST_SLAVE_ADDR 8'h00
`define RST_SLAVE_MASK 8'h00
`define MASK_SHARE_CTRL 8'hF3
`endif

/* File: shared/port5_cfg_pkg.sv */
// types shared by the port configuration bank
package port5_cfg_pkg;
  typedef enum logic [1:0] {
    baud_1m8432 = 2'b00,
    baud_18m432 = 2'b01,
    baud_24m = 2'b10,
    baud_14m769 = 2'b11
  } baud_source_t;

  typedef struct packed {
    logic multidrop_on;
    logic hw_address_match_on;
    logic direction_polarity_flip;
    logic direction_auto_drive_on;
    logic irq_share_style;
    logic irq_shared_flag;
  } share_ctrl_t;

  typedef struct packed {
    logic [7:0] slave_address_value;
    logic [7:0] slave_address_mask;
  } match_cfg_t;
endpackage : port5_cfg_pkg

/* File: logic/address_matcher.sv */
// given and broadcast address comparison for multi-drop reception
`timescale 1ns/1ps
module address_matcher (
  input wire logic mclk,
  input wire logic reset,
  input wire port5_cfg_pkg::match_cfg_t cfg,
  input wire logic [7:0] rx_address,
  input wire logic rx_address_valid,
  output logic hit_reg
);
  logic [7:0] broadcast_care;
  logic given_hit;
  logic broadcast_hit;

  // mask bit 0 makes that address bit don't-care
  assign given_hit = ((rx_address ^ cfg.slave_address_value) & cfg.slave_address_mask) == 8'h00; // RULE12
  // or of address and mask: 1 bits compared against received address
  assign broadcast_care = cfg.slave_address_value | cfg.slave_address_mask; // RULE13
  assign broadcast_hit = (rx_address & broadcast_care) == broadcast_care; // RULE13

  always_ff @(posedge mclk) begin
    if (reset) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= rx_address_valid & (given_hit | broadcast_hit); // RULE14
    end
  end
endmodule : address_matcher

/* File: logic/port5_config_bank.sv */
// configuration register bank of the fifth serial port
// What this block does
// RULE1: index 30h bit 0 switches the port on, resets to 0, bits 7 to 1 reserved.
// RULE2: index 60h holds the high byte of the I/O base address, reset 00h.
// RULE3: index 61h holds the low byte of the I/O base address, reset 00h.
// RULE4: index 70h bits 3 to 0 pick the interrupt channel, reset 3h, upper bits reserved.
// RULE5: index F0h bit 7 selects multi-drop 9-bit operation, parity position carries the flag.
// RULE6: index F0h bit 6 lets hardware clear the receive gate on an address match in 9-bit mode.
// RULE7: index F0h bit 4 drives request-to-send high while transmitting, low otherwise.
// RULE8: index F0h bit 5 inverts the auto-driven request-to-send when that drive is on.
// RULE9: index F0h bit 0 marks the interrupt as shared, reset 0.
// RULE10: index F0h bit 1 picks the sharing style when shared, bits 3 to 2 reserved.
// RULE11: index F2h bits 1 to 0 pick the baud clock source, reset 00b, bits 7 to 2 reserved.
// RULE12: given address ignores bits where the mask is 0 and compares the rest.
// RULE13: broadcast address compares only bits where address or mask is 1.
// RULE14: in 9-bit mode a match on either the given or the broadcast address is answered.
// RULE15: index F4h holds the slave address and index F5h the mask, both read/write.
// RULE16: reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`include "port5_cfg_consts.svh"
module port5_config_bank (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic tx_active,
  input wire logic [7:0] rx_address,
  input wire logic rx_address_valid,
  input wire logic rx_gate_set,
  output logic port_on,
  output logic [15:0] io_base,
  output logic [3:0] irq_channel_pick,
  output logic multidrop_on,
  output logic irq_shared_flag,
  output logic irq_share_style,
  output port5_cfg_pkg::baud_source_t baud_clock_source,
  output logic receive_gate_flag,
  output logic address_hit,
  output logic rts_n
);
  logic port_on_reg;
  logic [7:0] base_high_reg;
  logic [7:0] base_low_reg;
  logic [3:0] irq_channel_reg;
  port5_cfg_pkg::share_ctrl_t share_reg;
  port5_cfg_pkg::baud_source_t baud_reg;
  port5_cfg_pkg::match_cfg_t match_reg;
  logic gate_reg;
  logic rts_reg;
  logic out_en_reg;
  logic [15:0] out_base_reg;
  logic [3:0] out_irq_reg;
  logic out_multi_reg;
  logic out_shared_reg;
  logic out_style_reg;
  port5_cfg_pkg::baud_source_t out_baud_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic hit_reg;
  logic gate_clear_wr;

  function automatic logic idx_write(input logic [7:0] idx);
    idx_write = wr && (addr == idx);
  endfunction : idx_write

  always_ff @(posedge mclk) begin
    if (reset) begin
      port_on_reg <= 1'b0;
    end else if (idx_write(`IDX_PORT_ENABLE)) begin
      port_on_reg <= wdata[`BIT_PORT_ON]; // RULE1
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      base_high_reg <= `RST_BASE_HIGH;
      base_low_reg <= `RST_BASE_LOW;
    end else begin
      if (idx_write(`IDX_BASE_HIGH)) begin
        base_high_reg <= wdata; // RULE2
      end
      if (idx_write(`IDX_BASE_LOW)) begin
        base_low_reg <= wdata; // RULE3
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_channel_reg <= `RST_IRQ_CHANNEL;
    end else if (idx_write(`IDX_IRQ_CHANNEL)) begin
      irq_channel_reg <= wdata[3:0]; // RULE4
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      share_reg <= '0;
    end else if (idx_write(`IDX_SHARE_CTRL)) begin
      share_reg.multidrop_on <= wdata[`BIT_MULTIDROP_ON]; // RULE5
      share_reg.hw_address_match_on <= wdata[`BIT_HW_MATCH_ON]; // RULE6
      share_reg.direction_polarity_flip <= wdata[`BIT_POLARITY_FLIP]; // RULE8
      share_reg.direction_auto_drive_on <= wdata[`BIT_AUTO_DRIVE_ON]; // RULE7
      share_reg.irq_share_style <= wdata[`BIT_SHARE_STYLE]; // RULE10
      share_reg.irq_shared_flag <= wdata[`BIT_SHARED_FLAG]; // RULE9
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      baud_reg <= port5_cfg_pkg::baud_1m8432;
    end else if (idx_write(`IDX_BAUD_CLOCK)) begin
      baud_reg <= port5_cfg_pkg::baud_source_t'(wdata[1:0]); // RULE11
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      match_reg.slave_address_value <= `RST_SLAVE_ADDR;
      match_reg.slave_address_mask <= `RST_SLAVE_MASK;
    end else begin
      if (idx_write(`IDX_SLAVE_ADDR)) begin
        match_reg.slave_address_value <= wdata; // RULE15
      end
      if (idx_write(`IDX_SLAVE_MASK)) begin
        match_reg.slave_address_mask <= wdata; // RULE15
      end
    end
  end

  address_matcher matcher (
    .mclk(mclk),
    .reset(reset),
    .cfg(match_reg),
    .rx_address(rx_address),
    .rx_address_valid(rx_address_valid & share_reg.multidrop_on), // RULE14
    .hit_reg(hit_reg)
  );

  // software clears the gate by writing 1 to bit 0 of the status index
  assign gate_clear_wr = idx_write(`IDX_RX_STATUS) && wdata[0];

  // receive gate: set by receiver, cleared by host or by an address hit; set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      gate_reg <= 1'b0;
    end else if (rx_gate_set) begin
      gate_reg <= 1'b1;
    end else if (share_reg.multidrop_on && share_reg.hw_address_match_on && hit_reg) begin
      gate_reg <= 1'b0; // RULE6
    end else if (gate_clear_wr) begin
      gate_reg <= 1'b0; // RULE6
    end
  end

  // direction output, active low pin; idle high in rs232 mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      rts_reg <= 1'b1;
    end else if (share_reg.direction_auto_drive_on) begin
      rts_reg <= tx_active ^ share_reg.direction_polarity_flip; // RULE7 RULE8
    end else begin
      rts_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      out_en_reg <= 1'b0;
      out_base_reg <= 16'h0000;
      out_irq_reg <= `RST_IRQ_CHANNEL;
      out_multi_reg <= 1'b0;
      out_shared_reg <= 1'b0;
      out_style_reg <= 1'b0;
      out_baud_reg <= port5_cfg_pkg::baud_1m8432;
    end else begin
      out_en_reg <= port_on_reg; // RULE1
      out_base_reg <= {base_high_reg, base_low_reg}; // RULE2 RULE3
      out_irq_reg <= irq_channel_reg; // RULE4
      out_multi_reg <= share_reg.multidrop_on; // RULE5
      out_shared_reg <= share_reg.irq_shared_flag; // RULE9
      out_style_reg <= share_reg.irq_shared_flag & share_reg.irq_share_style; // RULE10
      out_baud_reg <= baud_reg; // RULE11
    end
  end

  // read mux; reserved bits and unmapped indices read zero
  always_comb begin
    rdata_next = 8'h00;
    case (addr)
      `IDX_PORT_ENABLE: rdata_next = {7'h00, port_on_reg}; // RULE16
      `IDX_BASE_HIGH: rdata_next = base_high_reg;
      `IDX_BASE_LOW: rdata_next = base_low_reg;
      `IDX_IRQ_CHANNEL: rdata_next = {4'h0, irq_channel_reg}; // RULE16
      `IDX_SHARE_CTRL: rdata_next = {share_reg.multidrop_on, share_reg.hw_address_match_on,
        share_reg.direction_polarity_flip, share_reg.direction_auto_drive_on, 2'b00,
        share_reg.irq_share_style, share_reg.irq_shared_flag}; // RULE16
      `IDX_BAUD_CLOCK: rdata_next = {6'h00, baud_reg}; // RULE16
      `IDX_SLAVE_ADDR: rdata_next = match_reg.slave_address_value;
      `IDX_SLAVE_MASK: rdata_next = match_reg.slave_address_mask;
      `IDX_RX_STATUS: rdata_next = {6'h00, hit_reg, gate_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign port_on = out_en_reg;
  assign io_base = out_base_reg;
  assign irq_channel_pick = out_irq_reg;
  assign multidrop_on = out_multi_reg;
  assign irq_shared_flag = out_shared_reg;
  assign irq_share_style = out_style_reg;
  assign baud_clock_source = out_baud_reg;
  assign receive_gate_flag = gate_reg;
  assign address_hit = hit_reg;
  assign rts_n = rts_reg;
endmodule : port5_config_bank

/* File: tb/cfg_props.sv */
// concurrent checks on the port configuration bank ports
`timescale 1ns/1ps
module cfg_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_active,
  input wire logic [7:0] rx_address,
  input wire logic rx_address_valid,
  input wire logic rx_gate_set,
  input wire logic port_on,
  input wire logic [3:0] irq_channel_pick,
  input wire logic multidrop_on,
  input wire logic irq_shared_flag,
  input wire logic irq_share_style,
  input wire port5_cfg_pkg::baud_source_t baud_clock_source,
  input wire logic receive_gate_flag,
  input wire logic address_hit,
  input wire logic rts_n
);
  logic [7:0] sa_reg, sm_reg, bc;
  logic drv_reg, flip_reg, md_reg, hit_exp;
  assign bc = sa_reg | sm_reg;
  assign hit_exp = (((rx_address ^ sa_reg) & sm_reg) == 8'h00) || ((rx_address & bc) == bc);
  // shadow of the match and direction settings
  always_ff @(posedge mclk) begin
    if (reset)
      {sa_reg, sm_reg, drv_reg, flip_reg, md_reg} <= 19'h00000;
    else if (wr && addr == 8'hF4)
      sa_reg <= wdata;
    else if (wr && addr == 8'hF5)
      sm_reg <= wdata;
    else if (wr && addr == 8'hF0)
      {md_reg, flip_reg, drv_reg} <= {wdata[7], wdata[5:4]};
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  port_on_lag_a: assert property (wr && addr == 8'h30 |-> ##2
    {7'h00, port_on} == ($past(wdata, 2) & 8'h01)) else $error("port_on wrong");
  chan_lag_a: assert property (wr && addr == 8'h70 |-> ##2
    {4'h0, irq_channel_pick} == ($past(wdata, 2) & 8'h0F)) else $error("channel wrong");
  baud_lag_a: assert property (wr && addr == 8'hF2 |-> ##2
    {6'h00, baud_clock_source} == ($past(wdata, 2) & 8'h03)) else $error("baud wrong");
  reserved_zero_a: assert property (rd && addr == 8'h70 |=> rdata[7:4] == 4'h0)
    else $error("reserved bits set");
  style_shared_a: assert property (irq_share_style |-> irq_shared_flag)
    else $error("style without share");
  match_hit_a: assert property (rx_address_valid && md_reg |=>
    address_hit == $past(hit_exp)) else $error("hit wrong");
  gate_set_a: assert property (rx_gate_set |=> receive_gate_flag)
    else $error("gate not set");
  rts_level_a: assert property (rts_n ==
    ($past(drv_reg) ? ($past(tx_active) ^ $past(flip_reg)) : 1'b1)) else $error("rts wrong");
endmodule : cfg_props
bind port5_config_bank cfg_props chk (.mclk, .reset, .addr, .wdata, .wr, .rd, .rdata,
  .tx_active, .rx_address, .rx_address_valid, .rx_gate_set, .port_on, .irq_channel_pick,
  .multidrop_on, .irq_shared_flag, .irq_share_style, .baud_clock_source,
  .receive_gate_flag, .address_hit, .rts_n);

/* File: tb/tb_port5_config_bank.sv */
// self-checking bench for the port configuration bank
`timescale 1ns/1ps
module tb_port5_config_bank;
  logic mclk, reset, wr, rd, tx_active, rx_address_valid, rx_gate_set, port_on, multidrop_on;
  logic irq_shared_flag, irq_share_style, receive_gate_flag, address_hit, rts_n;
  logic [7:0] addr, wdata, rdata, rx_address, d;
  logic [15:0] io_base;
  logic [3:0] irq_channel_pick;
  port5_cfg_pkg::baud_source_t baud_clock_source;
  int miscompares = 0, total_checks = 0, cycles = 0;
  logic [7:0] idx [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hF0, 8'hF2, 8'hF4, 8'hF5, 8'h55};
  logic [7:0] keep_v [9] = '{8'h01, 8'hFF, 8'hFF, 8'h0F, 8'hF3, 8'h03, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] rxa [6] = '{8'h58, 8'h5E, 8'hFF, 8'hFD, 8'h5D, 8'h00};
  port5_config_bank dut (.mclk, .reset, .addr, .wdata, .wr, .rd, .rdata, .tx_active,
    .rx_address, .rx_address_valid, .rx_gate_set, .port_on, .io_base, .irq_channel_pick,
    .multidrop_on, .irq_shared_flag, .irq_share_style, .baud_clock_source,
    .receive_gate_flag, .address_hit, .rts_n);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  task automatic send(input logic [7:0] a);
    @(posedge mclk);
    rx_address_valid <= 1'b1;
    rx_address <= a;
    @(posedge mclk);
    rx_address_valid <= 1'b0;
    #1;
  endtask : send
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    reset = 1'b1;
    {wr, rd, tx_active, rx_address_valid, rx_gate_set} = 5'h00;
    {addr, wdata, rx_address} = 24'h000000;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    #1 chk("rts_idle", 16'h0001, rts_n);
    for (int i = 0; i < 9; i++) begin
      rd_reg(idx[i]);
      chk("reset_read", (idx[i] == 8'h70) ? 16'h0003 : 16'h0000, d);
    end
    for (int i = 0; i < 9; i++) begin
      wr_reg(idx[i], 8'hFF);
      rd_reg(idx[i]);
      chk("masked_read", keep_v[i], d);
    end
    settle();
    chk("io_base", 16'hFFFF, io_base);
    chk("port_on", 16'h0001, port_on);
    chk("style", 16'h0001, irq_share_style);
    chk("shared", 16'h0001, irq_shared_flag);
    chk("multidrop", 16'h0001, multidrop_on);
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'hF2, 8'(k));
      settle();
      chk("baud", 16'(k), baud_clock_source);
    end
    wr_reg(8'hF0, 8'h10);
    for (int k = 0; k < 4; k++) begin
      if (k == 2)
        wr_reg(8'hF0, 8'h30);
      @(posedge mclk);
      tx_active <= k[0];
      settle();
      chk("rts", 16'(k[0] ^ k[1]), rts_n);
    end
    wr_reg(8'hF4, 8'h5C);
    wr_reg(8'hF5, 8'hF9);
    wr_reg(8'hF0, 8'hC0);
    settle();
    chk("rts_off", 16'h0001, rts_n);
    for (int i = 0; i < 6; i++) begin
      send(rxa[i]);
      chk("hit", 16'(i < 4), address_hit);
    end
    @(posedge mclk);
    rx_gate_set <= 1'b1;
    @(posedge mclk);
    rx_gate_set <= 1'b0;
    #1 chk("gate_set", 16'h0001, receive_gate_flag);
    send(8'h5C);
    @(posedge mclk);
    #1 chk("gate_hw_clear", 16'h0000, receive_gate_flag);
    wr_reg(8'hF0, 8'h80);
    @(posedge mclk);
    rx_gate_set <= 1'b1;
    @(posedge mclk);
    rx_gate_set <= 1'b0;
    send(8'h5C);
    @(posedge mclk);
    #1 chk("gate_kept", 16'h0001, receive_gate_flag);
    rd_reg(8'hF6);
    chk("status_read", 16'h0001, d);
    wr_reg(8'hF6, 8'h01);
    #1 chk("gate_host_clear", 16'h0000, receive_gate_flag);
    report_and_stop();
  end
endmodule : tb_port5_config_bank
